// file: rtl/mms_defs.svh
`ifndef MMS_DEFS_SVH
`define MMS_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define MMS_OFS_DAC_FIRST   8'h10
`define MMS_OFS_DAC_LAST    8'h17
`define MMS_OFS_MON_CTL     8'h18
`define MMS_OFS_CHAN_CTL    8'h19
`define MMS_OFS_CONV_CTL    8'h1A
`define MMS_OFS_DAC_SETUP   8'h1B
`define MMS_OFS_LOAD_SETUP  8'h1C

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define MMS_MON_START       0
`define MMS_MON_DIODE_LO    1
`define MMS_MON_DIODE_HI    2
`define MMS_MON_INT_EN      5
`define MMS_MON_INT_POL     6
`define MMS_MON_SOFT_RST    7
`define MMS_CHAN_SEL_HI     2
`define MMS_CHAN_SINGLE     4
`define MMS_CHAN_AVG_OFF    5
`define MMS_CHAN_SMB_TO     6
`define MMS_CONV_FAST       0
`define MMS_CONV_UPD_SRC    3
`define MMS_CONV_REF_VDD    4
`define MMS_CONV_TRACK_A    5
`define MMS_CONV_TRACK_B    6
`define MMS_LOAD_INT_REF    4

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define MMS_RST_CTL         8'h00

////////////////////////////////////////////////////////////////////////////////
// Timing
`define MMS_SYS_CLK_HZ      20000000
`define MMS_CAL_TIME_US     5000
`define MMS_ADC_FAST_HZ     22000
`define MMS_ADC_SLOW_HZ     1400
`define MMS_AVG_COUNT       16
`define MMS_CAL_CYCLES      (`MMS_CAL_TIME_US * (`MMS_SYS_CLK_HZ / 1000000))
`define MMS_FAST_HALF       (`MMS_SYS_CLK_HZ / (2 * `MMS_ADC_FAST_HZ))
`define MMS_SLOW_HALF       (`MMS_SYS_CLK_HZ / (2 * `MMS_ADC_SLOW_HZ))

`endif

// file: rtl/mms_pkg.sv
package mms_pkg;

    typedef enum logic [1:0] {
        MMS_ST_CAL   = 2'b00,
        MMS_ST_IDLE  = 2'b01,
        MMS_ST_START = 2'b10,
        MMS_ST_WAIT  = 2'b11
    } mms_state_t;

    typedef enum logic [2:0] {
        MMS_CH_VDD   = 3'b000,
        MMS_CH_ITEMP = 3'b001,
        MMS_CH_ETEMP = 3'b010,
        MMS_CH_ANALOG_INPUT_ONE  = 3'b011,
        MMS_CH_ANALOG_INPUT_TWO  = 3'b100,
        MMS_CH_ANALOG_INPUT_THREE  = 3'b101,
        MMS_CH_ANALOG_INPUT_FOUR  = 3'b110,
        MMS_CH_BAD   = 3'b111
    } mms_ch_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mms_reg_req_t;

    typedef struct packed {
        mms_ch_t    ch;
        logic [9:0] data;
    } mms_result_t;

endpackage

// file: rtl/mms_dac_bank.sv
`timescale 1ns/1ps
module mms_dac_bank #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rstn,
    input  wire logic                       i_ce,
    // Write port
    input  wire logic                       i_we,
    input  wire logic [$clog2(DEPTH)-1:0]   i_addr,
    input  wire logic [WIDTH-1:0]           i_wdata,
    // Whole contents
    output logic      [DEPTH*WIDTH-1:0]     o_all
);

    logic [DEPTH-1:0][WIDTH-1:0] mem_ff;

    // Pending DAC bytes
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mem_ff <= '0;
        end else if (i_ce && i_we) begin
            mem_ff[i_addr] <= i_wdata;
        end
    end

    assign o_all = mem_ff;

endmodule // mms_dac_bank

// file: rtl/mms_top.sv
`timescale 1ns/1ps
`include "mms_defs.svh"
module mms_top #(
    parameter int DAC_BITS   = 12,
    parameter int CAL_CYCLES = `MMS_CAL_CYCLES,
    parameter int SLOW_HALF  = `MMS_SLOW_HALF
) (
    // Clock and reset
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_rstn,
    input  wire logic                        i_ce,
    // Register access from serial front end
    input  mms_pkg::mms_reg_req_t            i_reg_req,
    output logic      [7:0]                  o_reg_rdata,
    output logic                             o_reg_rvalid,
    input  wire logic                        i_spi_select,
    output logic                             o_spi_mode,
    // Pins
    input  wire logic                        i_dac_load_strobe_n,
    // ADC side
    input  wire logic                        i_conv_done,
    input  wire logic [9:0]                  i_adc_data,
    output logic                             o_conv_start,
    output mms_pkg::mms_ch_t                 o_adc_ch,
    output logic                             o_adc_clk,
    output logic                             o_adc_fast,
    output logic                             o_diode_filter_en,
    output logic                             o_diode_mode,
    output logic                             o_adc_ref_vdd,
    output mms_pkg::mms_result_t             o_result,
    output logic                             o_result_valid,
    // DAC side
    output logic      [4*DAC_BITS-1:0]       o_dac_code,
    output logic      [3:0]                  o_dac_gain2,
    output logic                             o_dac_int_ref,
    // Status and options
    output logic                             o_idle,
    output logic                             o_cal_disturbed,
    output logic                             o_int_en,
    output logic                             o_int_pol,
    output logic                             o_smbus_timeout_en
);
    import mms_pkg::*;

    localparam int CAL_W = $clog2(CAL_CYCLES + 1);
    localparam int FAST_HLF = `MMS_FAST_HALF;
    localparam int DIV_W = $clog2(((SLOW_HALF > FAST_HLF) ? SLOW_HALF : FAST_HLF) + 1);
    localparam int SHIFT = 16 - DAC_BITS;

    ////////////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic mms_ch_t next_ch(input mms_ch_t ch, input logic diode);
        mms_ch_t n;
        n = MMS_CH_VDD;
        unique case (ch)
            MMS_CH_VDD:   n = MMS_CH_ITEMP;
            MMS_CH_ITEMP: n = diode ? MMS_CH_ETEMP : MMS_CH_ANALOG_INPUT_ONE;
            MMS_CH_ETEMP: n = MMS_CH_ANALOG_INPUT_THREE;
            MMS_CH_ANALOG_INPUT_ONE:  n = MMS_CH_ANALOG_INPUT_TWO;
            MMS_CH_ANALOG_INPUT_TWO:  n = MMS_CH_ANALOG_INPUT_THREE;
            MMS_CH_ANALOG_INPUT_THREE:  n = MMS_CH_ANALOG_INPUT_FOUR;
            MMS_CH_ANALOG_INPUT_FOUR:  n = MMS_CH_VDD;
            default:      n = MMS_CH_VDD;
        endcase
        return n;
    endfunction

    function automatic logic [15:0] dac_word(input logic [DAC_BITS-1:0] code);
        return 16'(code) << SHIFT;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0]                  mon_ctl_ff;
    logic [7:0]                  chan_ctl_ff;
    logic [7:0]                  conv_ctl_ff;
    logic [7:0]                  dac_setup_ff;
    logic [7:0]                  load_setup_ff;
    logic                        spi_mode_ff;
    logic                        dac_load_strobe_n_meta_ff;
    logic                        dac_load_strobe_n_sync_ff;
    logic                        dac_load_strobe_n_prev_ff;
    logic                        done_meta_ff;
    logic                        done_sync_ff;
    logic                        done_prev_ff;
    logic [9:0]                  data_meta_ff;
    logic [9:0]                  data_sync_ff;
    mms_state_t                  state_ff;
    logic [CAL_W-1:0]            cal_cnt_ff;
    mms_ch_t                     ch_ff;
    logic [3:0]                  avg_cnt_ff;
    logic [13:0]                 acc_ff;
    logic                        avg_off_ff;
    logic                        fast_ff;
    logic                        conv_start_ff;
    mms_result_t                 result_ff;
    logic                        result_valid_ff;
    logic                        cal_dist_ff;
    logic                        idle_ff;
    logic                        diode_mode_ff;
    logic                        diode_filter_ff;
    logic [15:0]                 rd_word;
    logic [DIV_W-1:0]            div_cnt_ff;
    logic                        adc_clk_ff;
    logic [3:0][DAC_BITS-1:0]    dac_code_ff;
    logic [7:0]                  rdata_ff;
    logic                        rvalid_ff;
    logic [63:0]                 bank_all;
    logic                        wr_dac;
    logic                        dac_load_strobe_n_fall;
    logic                        done_rise;
    logic [3:0]                  load_mask;
    logic [13:0]                 acc_sum;
    logic                        last_conv;
    mms_ch_t                     first_ch;
    mms_ch_t                     nxt_ch;
    logic [7:0]                  nxt_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dac_load_strobe_n_meta_ff <= 1'b1;
            dac_load_strobe_n_sync_ff <= 1'b1;
            dac_load_strobe_n_prev_ff <= 1'b1;
            done_meta_ff <= 1'b0;
            done_sync_ff <= 1'b0;
            done_prev_ff <= 1'b0;
            data_meta_ff <= 10'h000;
            data_sync_ff <= 10'h000;
        end else if (i_ce) begin
            dac_load_strobe_n_meta_ff <= i_dac_load_strobe_n;
            dac_load_strobe_n_sync_ff <= dac_load_strobe_n_meta_ff;
            dac_load_strobe_n_prev_ff <= dac_load_strobe_n_sync_ff;
            done_meta_ff <= i_conv_done;
            done_sync_ff <= done_meta_ff;
            done_prev_ff <= done_sync_ff;
            data_meta_ff <= i_adc_data;
            data_sync_ff <= data_meta_ff;
        end
    end

    assign dac_load_strobe_n_fall = dac_load_strobe_n_prev_ff & ~dac_load_strobe_n_sync_ff;
    assign done_rise = done_sync_ff & ~done_prev_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    assign wr_dac = i_reg_req.wr && (i_reg_req.addr >= `MMS_OFS_DAC_FIRST)
                    && (i_reg_req.addr <= `MMS_OFS_DAC_LAST);

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mon_ctl_ff    <= `MMS_RST_CTL;
            diode_mode_ff <= 1'b1;
            chan_ctl_ff   <= `MMS_RST_CTL;
            conv_ctl_ff   <= `MMS_RST_CTL;
            dac_setup_ff  <= `MMS_RST_CTL;
            load_setup_ff <= `MMS_RST_CTL;
        end else if (i_ce && i_reg_req.wr) begin
            unique case (i_reg_req.addr)
                `MMS_OFS_MON_CTL: begin
                    if (i_reg_req.wdata[`MMS_MON_SOFT_RST]) begin
                        mon_ctl_ff    <= `MMS_RST_CTL;
                        chan_ctl_ff   <= `MMS_RST_CTL;
                        conv_ctl_ff   <= `MMS_RST_CTL;
                        dac_setup_ff  <= `MMS_RST_CTL;
                        load_setup_ff <= `MMS_RST_CTL;
                        diode_mode_ff <= 1'b1;
                    end else begin
                        mon_ctl_ff <= i_reg_req.wdata;
                        diode_mode_ff <= (i_reg_req.wdata[`MMS_MON_DIODE_HI:`MMS_MON_DIODE_LO]
                                          == 2'b00);
                    end
                end
                `MMS_OFS_CHAN_CTL:   chan_ctl_ff   <= i_reg_req.wdata;
                `MMS_OFS_CONV_CTL:   conv_ctl_ff   <= i_reg_req.wdata;
                `MMS_OFS_DAC_SETUP:  dac_setup_ff  <= i_reg_req.wdata;
                `MMS_OFS_LOAD_SETUP: load_setup_ff <= {3'h0, i_reg_req.wdata[4:0]};
                default: ;
            endcase
        end
    end

    // Serial protocol lock
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            spi_mode_ff <= 1'b0;
        end else if (i_ce && i_spi_select) begin
            spi_mode_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pending DAC bytes
    mms_dac_bank #(
        .DEPTH (8),
        .WIDTH (8)
    ) u_bank (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_we      (wr_dac),
        .i_addr    (i_reg_req.addr[2:0]),
        .i_wdata   (i_reg_req.wdata),
        .o_all     (bank_all)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // DAC load
    always_comb begin
        load_mask = 4'h0;
        if (conv_ctl_ff[`MMS_CONV_UPD_SRC]) begin
            if (i_reg_req.wr && i_reg_req.addr == `MMS_OFS_LOAD_SETUP) begin
                load_mask = i_reg_req.wdata[3:0];
            end
        end else if (dac_load_strobe_n_fall) begin
            load_mask = 4'hF;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dac_code_ff <= '0;
        end else if (i_ce) begin
            for (int n = 0; n < 4; n++) begin
                if (load_mask[n]) begin
                    dac_code_ff[n] <= DAC_BITS'(bank_all[16*n +: 16] >> SHIFT);
                end
            end
            if (result_valid_ff && result_ff.ch == MMS_CH_ITEMP
                && conv_ctl_ff[`MMS_CONV_TRACK_A]) begin
                dac_code_ff[0] <= DAC_BITS'(result_ff.data);
            end
            if (result_valid_ff && result_ff.ch == MMS_CH_ETEMP
                && conv_ctl_ff[`MMS_CONV_TRACK_B]) begin
                dac_code_ff[1] <= DAC_BITS'(result_ff.data);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign first_ch  = chan_ctl_ff[`MMS_CHAN_SINGLE]
                       ? mms_ch_t'(chan_ctl_ff[`MMS_CHAN_SEL_HI:0]) : MMS_CH_VDD;
    assign nxt_ch    = chan_ctl_ff[`MMS_CHAN_SINGLE] ? first_ch
                       : next_ch(ch_ff, mon_ctl_ff[`MMS_MON_DIODE_HI:`MMS_MON_DIODE_LO] == 2'b00);
    assign acc_sum   = acc_ff + 14'(data_sync_ff);
    assign last_conv = avg_off_ff || (avg_cnt_ff == 4'(`MMS_AVG_COUNT - 1));

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff        <= MMS_ST_CAL;
            cal_cnt_ff      <= '0;
            ch_ff           <= MMS_CH_VDD;
            avg_cnt_ff      <= 4'h0;
            acc_ff          <= 14'h0000;
            avg_off_ff      <= 1'b0;
            fast_ff         <= 1'b0;
            diode_filter_ff <= 1'b1;
            idle_ff         <= 1'b0;
            conv_start_ff   <= 1'b0;
            result_ff       <= '0;
            result_valid_ff <= 1'b0;
        end else if (i_ce) begin
            conv_start_ff   <= 1'b0;
            result_valid_ff <= 1'b0;
            unique case (state_ff)
                MMS_ST_CAL: begin
                    cal_cnt_ff <= cal_cnt_ff + 1'b1;
                    if (cal_cnt_ff == CAL_W'(CAL_CYCLES - 1)) begin
                        state_ff <= MMS_ST_IDLE;
                        idle_ff  <= 1'b1;
                    end
                end
                MMS_ST_IDLE: begin
                    if (mon_ctl_ff[`MMS_MON_START]) begin
                        ch_ff      <= first_ch;
                        avg_off_ff <= chan_ctl_ff[`MMS_CHAN_AVG_OFF];
                        fast_ff    <= conv_ctl_ff[`MMS_CONV_FAST];
                        diode_filter_ff <= ~conv_ctl_ff[`MMS_CONV_FAST];
                        idle_ff    <= 1'b0;
                        state_ff   <= MMS_ST_START;
                    end
                end
                MMS_ST_START: begin
                    conv_start_ff <= 1'b1;
                    state_ff      <= MMS_ST_WAIT;
                end
                MMS_ST_WAIT: begin
                    if (done_rise) begin
                        if (last_conv) begin
                            result_ff.ch    <= ch_ff;
                            result_ff.data  <= avg_off_ff ? data_sync_ff : acc_sum[13:4];
                            result_valid_ff <= 1'b1;
                            acc_ff          <= 14'h0000;
                            avg_cnt_ff      <= 4'h0;
                            ch_ff           <= nxt_ch;
                            avg_off_ff      <= chan_ctl_ff[`MMS_CHAN_AVG_OFF];
                            fast_ff         <= conv_ctl_ff[`MMS_CONV_FAST];
                            diode_filter_ff <= ~conv_ctl_ff[`MMS_CONV_FAST];
                            idle_ff         <= ~mon_ctl_ff[`MMS_MON_START];
                            state_ff        <= mon_ctl_ff[`MMS_MON_START]
                                               ? MMS_ST_START : MMS_ST_IDLE;
                        end else begin
                            acc_ff     <= acc_sum;
                            avg_cnt_ff <= avg_cnt_ff + 4'h1;
                            state_ff   <= MMS_ST_START;
                        end
                    end
                end
            endcase
        end
    end

    // Calibration disturbance
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cal_dist_ff <= 1'b0;
        end else if (i_ce && state_ff == MMS_ST_CAL && (i_reg_req.wr || i_reg_req.rd)) begin
            cal_dist_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ADC clock divider
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_cnt_ff <= '0;
            adc_clk_ff <= 1'b0;
        end else if (i_ce) begin
            if (div_cnt_ff >= (fast_ff ? DIV_W'(`MMS_FAST_HALF - 1)
                                       : DIV_W'(SLOW_HALF - 1))) begin
                div_cnt_ff <= '0;
                adc_clk_ff <= ~adc_clk_ff;
            end else begin
                div_cnt_ff <= div_cnt_ff + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read
    assign rd_word = dac_word(dac_code_ff[i_reg_req.addr[2:1]]);

    always_comb begin
        nxt_rdata = 8'h00;
        unique case (i_reg_req.addr)
            `MMS_OFS_MON_CTL:    nxt_rdata = mon_ctl_ff;
            `MMS_OFS_CHAN_CTL:   nxt_rdata = chan_ctl_ff;
            `MMS_OFS_CONV_CTL:   nxt_rdata = conv_ctl_ff;
            `MMS_OFS_DAC_SETUP:  nxt_rdata = dac_setup_ff;
            `MMS_OFS_LOAD_SETUP: nxt_rdata = load_setup_ff;
            default: begin
                if (i_reg_req.addr >= `MMS_OFS_DAC_FIRST
                    && i_reg_req.addr <= `MMS_OFS_DAC_LAST) begin
                    nxt_rdata = rd_word[8*i_reg_req.addr[0] +: 8];
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end else if (i_ce) begin
            rvalid_ff <= i_reg_req.rd;
            if (i_reg_req.rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_reg_rdata        = rdata_ff;
    assign o_reg_rvalid       = rvalid_ff;
    assign o_spi_mode         = spi_mode_ff;
    assign o_conv_start       = conv_start_ff;
    assign o_adc_ch           = ch_ff;
    assign o_adc_clk          = adc_clk_ff;
    assign o_adc_fast         = fast_ff;
    assign o_diode_filter_en  = diode_filter_ff;
    assign o_diode_mode       = diode_mode_ff;
    assign o_adc_ref_vdd      = conv_ctl_ff[`MMS_CONV_REF_VDD];
    assign o_result           = result_ff;
    assign o_result_valid     = result_valid_ff;
    assign o_dac_code         = dac_code_ff;
    assign o_dac_gain2        = dac_setup_ff[3:0];
    assign o_dac_int_ref      = load_setup_ff[`MMS_LOAD_INT_REF];
    assign o_idle             = idle_ff;
    assign o_cal_disturbed    = cal_dist_ff;
    assign o_int_en           = mon_ctl_ff[`MMS_MON_INT_EN];
    assign o_int_pol          = mon_ctl_ff[`MMS_MON_INT_POL];
    assign o_smbus_timeout_en = chan_ctl_ff[`MMS_CHAN_SMB_TO];

endmodule // mms_top

// file: verif/mms_adc_model.sv
`timescale 1ns/1ps
module mms_adc_model (
    // Clock
    input  wire logic        i_sys_clk,
    // Conversion request
    input  wire logic        i_start,
    input  mms_pkg::mms_ch_t i_ch,
    // Conversion answer
    output logic             o_done,
    output logic [9:0]       o_data
);
    import mms_pkg::*;
    logic link_clk = 1'b0;
    int   n_conv   = 0;
    // Converter oscillator, free running
    always #200 link_clk = ~link_clk;
    // Alternating quick and slow conversions
    initial begin
        o_done = 1'b0;
        o_data = 10'h2AA;
        forever begin
            @(posedge i_sys_clk iff i_start);
            n_conv++;
            o_done <= 1'b0;
            o_data <= ~o_data;
            repeat (n_conv % 2 ? 2 : 9) @(posedge link_clk);
            o_data <= {7'h15, i_ch};
            @(posedge link_clk);
            o_done <= 1'b1;
        end
    end
endmodule // mms_adc_model

// file: verif/mms_top_sva.sv
`timescale 1ns/1ps
module mms_top_sva (
    // Clock and reset
    input wire logic             i_sys_clk,
    input wire logic             i_rstn,
    // Watched ports
    input wire logic             i_ce,
    input mms_pkg::mms_reg_req_t i_reg_req,
    input wire logic             o_reg_rvalid,
    input wire logic             i_spi_select,
    input wire logic             o_spi_mode,
    input wire logic             o_conv_start,
    input wire logic             o_result_valid,
    input wire logic             o_idle,
    input wire logic             o_adc_fast,
    input wire logic             o_diode_filter_en
);
    import mms_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    sequence rd_take;
        i_ce && i_reg_req.rd;
    endsequence
    sequence spi_take;
        i_ce && i_spi_select;
    endsequence
    rvalid_timing_a: assert property (rd_take |=> o_reg_rvalid)
        else $error("read answer missing");
    rvalid_cause_a: assert property (o_reg_rvalid |-> $past(i_ce && i_reg_req.rd))
        else $error("read answer without read");
    filter_fast_a: assert property (o_diode_filter_en != o_adc_fast)
        else $error("diode filter wrong for speed");
    conv_pulse_a: assert property (o_conv_start |=> !o_conv_start)
        else $error("conversion start too long");
    idle_quiet_a: assert property (o_idle |-> !o_conv_start)
        else $error("conversion while idle");
    result_pulse_a: assert property (o_result_valid |=> !o_result_valid)
        else $error("result valid too long");
    spi_select_a: assert property (spi_take |=> o_spi_mode)
        else $error("serial mode not switched");
    spi_lock_a: assert property ($rose(o_spi_mode) |=> o_spi_mode[*8])
        else $error("serial mode lock lost");
endmodule // mms_top_sva
bind mms_top mms_top_sva u_mms_top_sva (.*);

// file: verif/tb_mms_top.sv
`timescale 1ns/1ps
module tb_mms_top;
    import mms_pkg::*;
    logic i_sys_clk, i_rstn, i_ce, i_spi_select, i_dac_load_strobe_n, i_conv_done;
    logic o_reg_rvalid, o_spi_mode, o_conv_start, o_adc_fast, o_diode_filter_en;
    logic o_diode_mode, o_adc_ref_vdd, o_result_valid, o_idle, o_cal_disturbed;
    logic o_int_en, o_int_pol;
    logic [7:0] o_reg_rdata;
    logic [9:0] i_adc_data;
    logic [47:0] o_dac_code;
    mms_reg_req_t i_reg_req;
    mms_ch_t o_adc_ch;
    mms_result_t o_result;
    int fail_count = 0, n_checks = 0, n_conv = 0, got_n = 0;
    mms_ch_t rr[5] = '{MMS_CH_ITEMP, MMS_CH_ETEMP, MMS_CH_ANALOG_INPUT_THREE, MMS_CH_ANALOG_INPUT_FOUR, MMS_CH_VDD};
    mms_top #(.CAL_CYCLES(20), .SLOW_HALF(10)) u_mms_top (.*, .o_adc_clk(), .o_dac_gain2(),
        .o_dac_int_ref(), .o_smbus_timeout_en());
    mms_adc_model u_mms_adc_model (.i_sys_clk, .i_start(o_conv_start), .i_ch(o_adc_ch),
        .o_done(i_conv_done), .o_data(i_adc_data));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge i_sys_clk);
        i_reg_req <= '0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_sys_clk);
        i_reg_req <= '0;
        #1 chk({o_reg_rvalid, o_reg_rdata}, {1'b1, exp});
        @(posedge i_sys_clk);
    endtask
    task automatic wres();
        repeat (3000) begin
            @(posedge i_sys_clk);
            #1;
            if (o_result_valid === 1'b1) break;
        end
        chk(o_result_valid, 1'b1);
        got_n = n_conv;
        n_conv = 0;
        @(posedge i_sys_clk);
    endtask
    task automatic pulse();
        i_dac_load_strobe_n <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        i_dac_load_strobe_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
    endtask
    task automatic close_out();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge i_sys_clk) if (o_conv_start === 1'b1) n_conv <= n_conv + 1;
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        #2000000;
        fail_count++;
        close_out();
    end
    initial begin
        {i_rstn, i_ce, i_spi_select, i_dac_load_strobe_n, i_reg_req} = {4'b0101, 18'h0};
        repeat (16) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        rd(8'h19, 8'h00);
        repeat (22) @(posedge i_sys_clk);
        chk({o_idle, o_cal_disturbed, o_spi_mode, o_adc_fast, o_dac_code}, {4'hC, 48'h0});
        wr(8'h18, 8'h62);
        chk({o_int_en, o_int_pol, o_diode_mode}, 3'b110);
        rd(8'h18, 8'h62);
        rd(8'h30, 8'h00);
        wr(8'h1A, 8'h10);
        chk(o_adc_ref_vdd, 1'b1);
        wr(8'h10, 8'hCD);
        wr(8'h11, 8'hAB);
        rd(8'h11, 8'h00);
        pulse();
        chk(o_dac_code[11:0], 12'hABC);
        rd(8'h11, 8'hAB);
        wr(8'h1A, 8'h08);
        wr(8'h12, 8'h50);
        wr(8'h13, 8'h34);
        pulse();
        chk(o_dac_code[23:12], 12'h000);
        wr(8'h1C, 8'h12);
        chk(o_dac_code[23:12], 12'h345);
        wr(8'h18, 8'h01);
        wres();
        chk({o_result, got_n}, {MMS_CH_VDD, 7'h15, MMS_CH_VDD, 32'd16});
        wr(8'h19, 8'h20);
        for (int i = 0; i < 5; i++) begin
            wres();
            chk({o_result, got_n}, {rr[i], 7'h15, rr[i], i == 0 ? 32'd16 : 32'd1});
        end
        wr(8'h1A, 8'h21);
        wres();
        wres();
        chk({o_adc_fast, o_diode_filter_en}, 2'b10);
        chk(o_dac_code[11:0], {5'h00, 7'h15, MMS_CH_ITEMP});
        wr(8'h19, 8'h35);
        wres();
        wres();
        chk(o_result.ch, MMS_CH_ANALOG_INPUT_THREE);
        wr(8'h18, 8'h00);
        repeat (3000) if (o_idle !== 1'b1) @(posedge i_sys_clk);
        chk(o_idle, 1'b1);
        i_ce <= 1'b0;
        wr(8'h1C, 8'h00);
        i_ce <= 1'b1;
        rd(8'h1C, 8'h12);
        i_spi_select <= 1'b1;
        @(posedge i_sys_clk);
        i_spi_select <= 1'b0;
        wr(8'h18, 8'h80);
        chk(o_spi_mode, 1'b1);
        rd(8'h18, 8'h00);
        close_out();
    end
endmodule // tb_mms_top
